// [hdl/trh_device.sv]
/*
  Device end: eight host locations over fourteen registers, packet RAM
  window, maskable flags onto one interrupt, and the microsequencer.
  Assumes the host end drives one-cycle strobes on the shared clock.
*/
`default_nettype none
module trh_device
  import trh_pkg::*;
#(
  parameter int REBUILD_LEN = trh_pkg::REBUILD_CYCLES
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Host register bus
  trh_bus_if.device        bus,
  // Network-side events
  input  wire logic        rxInhibit,
  input  wire logic        txAvail,
  input  wire logic        excessNakEvt,
  input  wire logic        successorLoad,
  input  wire logic [7:0]  successorIn,
  // Command and configuration outputs
  output logic             cmdStrobe,
  output logic [7:0]       cmdCode,
  output logic [7:0]       probeStation,
  output logic [7:0]       ownStation,
  output logic [7:0]       linkSetupA,
  output logic [7:0]       linkSetupB,
  output logic [5:0]       configHi,
  output logic [trh_pkg::ROM_AW-1:0] seqPc
);
  logic [7:0] ram [0:(1 << RAM_AW)-1];
  logic [7:0] mask, next_mask, dataWin, next_dataWin, successor, next_successor;
  logic [7:0] next_probe, next_own, next_setupA, next_setupB, next_cmdCode;
  logic [7:0] next_rdata, statusVec, diagVec, irqSrc;
  logic [RAM_AW-1:0] ptr, next_ptr, ptrInc;
  logic [2:0] pageSel, next_pageSel;
  logic [1:0] pageHi, next_pageHi;
  logic [5:0] next_configHi;
  logic rdMode, next_rdMode, autoInc, next_autoInc, ramWe;
  logic riFlag, taFlag, reconFlag, localFlag, excFlag, succFlag, porFlag;
  logic next_topology_rebuild_flag, next_local, next_exc, next_succ, next_por;
  logic next_cmdStrobe, next_irq, clrFlags, porClr, succRead, rebuildEvt;
  logic [trh_pkg::ROM_AW-1:0] pcWire;

  // --------------------------------------------------------------
  // Microsequencer
  // --------------------------------------------------------------
  trh_sequencer #(.REBUILD_LEN(REBUILD_LEN)) trh_sequencer_i (
    .clk        (clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .pc         (pcWire),
    .rebuildEvt (rebuildEvt)
  );

  // --------------------------------------------------------------
  // Register file next values
  // --------------------------------------------------------------
  always_comb
  begin
    ptrInc = ptr + 1'b1;
    statusVec = 8'h00;
    statusVec[BIT_RI] = riFlag;
    statusVec[BIT_POR] = porFlag;
    statusVec[BIT_TOPOLOGY_REBUILD_FLAG] = reconFlag;
    statusVec[BIT_TA] = taFlag;
    diagVec = 8'h00;
    diagVec[BIT_LOCAL] = localFlag;
    diagVec[BIT_EXCESS_NEG_ACK_FLAG] = excFlag;
    diagVec[BIT_SUCC] = succFlag;
    irqSrc = 8'h00;
    irqSrc[BIT_RI] = riFlag;
    irqSrc[BIT_EXCESS_NEG_ACK_FLAG] = excFlag;
    irqSrc[BIT_TOPOLOGY_REBUILD_FLAG] = reconFlag;
    irqSrc[BIT_SUCC] = succFlag;
    irqSrc[BIT_TA] = taFlag;
    next_mask = mask;
    next_ptr = ptr;
    next_rdMode = rdMode;
    next_autoInc = autoInc;
    next_dataWin = dataWin;
    next_pageSel = pageSel;
    next_pageHi = pageHi;
    next_configHi = configHi;
    next_probe = probeStation;
    next_own = ownStation;
    next_setupA = linkSetupA;
    next_setupB = linkSetupB;
    next_cmdCode = cmdCode;
    next_cmdStrobe = 1'b0;
    next_rdata = bus.rdata;
    clrFlags = 1'b0;
    porClr = 1'b0;
    succRead = 1'b0;
    ramWe = 1'b0;
    if (bus.wrStb)
    begin
      case (bus.loc)
        LOC_STATUS: next_mask = bus.wdata & IRQ_CAPABLE;
        LOC_DIAG:
        begin
          next_cmdStrobe = 1'b1;
          next_cmdCode = bus.wdata;
          clrFlags = (bus.wdata == CMD_CLEAR_FLAGS);
          porClr = (bus.wdata == CMD_POR_CLEAR);
        end
        LOC_PTR_HI:
        begin
          next_rdMode = bus.wdata[BIT_PTR_RD];
          next_autoInc = bus.wdata[BIT_PTR_INC];
          next_ptr = {bus.wdata[RAM_AW-9:0], ptr[7:0]};
        end
        LOC_PTR_LO:
        begin
          next_ptr = {ptr[RAM_AW-1:8], bus.wdata};
          if (rdMode)
            next_dataWin = ram[{ptr[RAM_AW-1:8], bus.wdata}];
        end
        LOC_DATA:
        begin
          ramWe = 1'b1;
          next_dataWin = bus.wdata;
          if (autoInc)
            next_ptr = ptrInc;
        end
        LOC_PAGE:
        begin
          next_pageHi = bus.wdata[7:6];
          next_pageSel = bus.wdata[2:0];
        end
        LOC_CONFIG:
        begin
          next_configHi = bus.wdata[7:2];
          next_pageSel = {pageSel[2], bus.wdata[1:0]};
        end
        default:
          case (pageSel)
            PG_PROBE:   next_probe = bus.wdata;
            PG_OWN:     next_own = bus.wdata;
            PG_SETUP_A: next_setupA = bus.wdata;
            PG_SETUP_B: next_setupB = bus.wdata;
            default:    next_setupB = linkSetupB;
          endcase
      endcase
    end
    if (bus.rdStb)
    begin
      case (bus.loc)
        LOC_STATUS: next_rdata = statusVec;
        LOC_DIAG:   next_rdata = diagVec;
        LOC_PTR_HI: next_rdata = {rdMode, autoInc, 3'h0, ptr[RAM_AW-1:8]};
        LOC_PTR_LO: next_rdata = ptr[7:0];
        LOC_DATA:
        begin
          next_rdata = dataWin;
          if (autoInc)
          begin
            next_ptr = ptrInc;
            next_dataWin = ram[ptrInc];
          end
        end
        LOC_PAGE:   next_rdata = {pageHi, 3'h0, pageSel};
        LOC_CONFIG: next_rdata = {configHi, pageSel[1:0]};
        default:
          case (pageSel)
            PG_PROBE:   next_rdata = probeStation;
            PG_OWN:     next_rdata = ownStation;
            PG_SETUP_A: next_rdata = linkSetupA;
            PG_SUCC:
            begin
              next_rdata = successor;
              succRead = 1'b1;
            end
            PG_SETUP_B: next_rdata = linkSetupB;
            default:    next_rdata = 8'h00;
          endcase
      endcase
    end
    next_topology_rebuild_flag = (reconFlag & ~clrFlags) | rebuildEvt;
    next_local = (localFlag & ~clrFlags) | rebuildEvt;
    next_exc = (excFlag & ~porClr) | excessNakEvt;
    next_por = porFlag & ~porClr;
    next_succ = (succFlag & ~succRead) | successorLoad;
    next_successor = successorLoad ? successorIn : successor;
    next_irq = |(mask & irqSrc);
  end

  // Packet RAM, no reset
  always_ff @(posedge clk)
  begin
    if (ce && ramWe)
      ram[ptr] <= bus.wdata;
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask <= MASK_RESET;
      porFlag <= POR_RESET[BIT_POR];
      ptr <= '0;
      rdMode <= 1'b0;
      autoInc <= 1'b0;
      dataWin <= 8'h00;
      pageSel <= 3'h0;
      pageHi <= 2'h0;
      configHi <= 6'h00;
      probeStation <= 8'h00;
      ownStation <= 8'h00;
      linkSetupA <= 8'h00;
      linkSetupB <= 8'h00;
      successor <= 8'h00;
      cmdCode <= 8'h00;
      cmdStrobe <= 1'b0;
      riFlag <= 1'b0;
      taFlag <= 1'b0;
      reconFlag <= 1'b0;
      localFlag <= 1'b0;
      excFlag <= 1'b0;
      succFlag <= 1'b0;
      bus.rdata <= 8'h00;
      bus.rdValid <= 1'b0;
      bus.irq <= 1'b0;
      seqPc <= '0;
    end
    else if (ce)
    begin
      mask <= next_mask;
      porFlag <= next_por;
      ptr <= next_ptr;
      rdMode <= next_rdMode;
      autoInc <= next_autoInc;
      dataWin <= next_dataWin;
      pageSel <= next_pageSel;
      pageHi <= next_pageHi;
      configHi <= next_configHi;
      probeStation <= next_probe;
      ownStation <= next_own;
      linkSetupA <= next_setupA;
      linkSetupB <= next_setupB;
      successor <= next_successor;
      cmdCode <= next_cmdCode;
      cmdStrobe <= next_cmdStrobe;
      riFlag <= rxInhibit;
      taFlag <= txAvail;
      reconFlag <= next_topology_rebuild_flag;
      localFlag <= next_local;
      excFlag <= next_exc;
      succFlag <= next_succ;
      bus.rdata <= next_rdata;
      bus.rdValid <= bus.rdStb;
      bus.irq <= next_irq;
      seqPc <= pcWire;
    end
  end
endmodule // trh_device
`default_nettype wire

// [hdl/trh_pkg.sv]
/*
  Shared constants of the network controller register bank: host locations,
  field positions, command codes, sequencer timing and the APB map of the
  host-side controller.
  Assumes a single 50 MHz clock shared by both ends.
*/
`default_nettype none
package trh_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DW      = 8;
  localparam int LOC_W   = 3;
  localparam int RAM_AW  = 11;
  localparam int ROM_AW  = 10;
  localparam int ROM_DEPTH = 544;
  // ---------------------------------------------------------------
  // Host locations and pages of location 7
  // ---------------------------------------------------------------
  localparam logic [2:0] LOC_STATUS = 3'h0;
  localparam logic [2:0] LOC_DIAG   = 3'h1;
  localparam logic [2:0] LOC_PTR_HI = 3'h2;
  localparam logic [2:0] LOC_PTR_LO = 3'h3;
  localparam logic [2:0] LOC_DATA   = 3'h4;
  localparam logic [2:0] LOC_PAGE   = 3'h5;
  localparam logic [2:0] LOC_CONFIG = 3'h6;
  localparam logic [2:0] LOC_PAGED  = 3'h7;
  localparam logic [2:0] PG_PROBE   = 3'h0;
  localparam logic [2:0] PG_OWN     = 3'h1;
  localparam logic [2:0] PG_SETUP_A = 3'h2;
  localparam logic [2:0] PG_SUCC    = 3'h3;
  localparam logic [2:0] PG_SETUP_B = 3'h4;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_RI     = 7;
  localparam int BIT_POR    = 4;
  localparam int BIT_TOPOLOGY_REBUILD_FLAG  = 2;
  localparam int BIT_TA     = 0;
  localparam int BIT_LOCAL  = 7;
  localparam int BIT_EXCESS_NEG_ACK_FLAG = 3;
  localparam int BIT_SUCC   = 1;
  localparam int BIT_PTR_RD = 7;
  localparam int BIT_PTR_INC = 6;
  localparam logic [7:0] IRQ_CAPABLE = 8'h8f;
  localparam logic [7:0] MASK_RESET  = 8'h00;
  localparam logic [7:0] POR_RESET   = 8'h10;
  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h1e;
  localparam logic [7:0] CMD_POR_CLEAR   = 8'h0e;
  // ---------------------------------------------------------------
  // Sequencer timing and opcodes
  // ---------------------------------------------------------------
  localparam int CLK_HZ  = 50_000_000;
  localparam int PC_HZ   = 10_000_000;
  localparam int EXEC_HZ = 5_000_000;
  localparam logic [2:0] PC_DIV_LAST = 3'(CLK_HZ / PC_HZ - 1);
  localparam int REBUILD_TIME_US = 1000;
  localparam int REBUILD_CYCLES  = REBUILD_TIME_US * (CLK_HZ / 1_000_000);
  localparam logic [1:0] OP_NOP  = 2'h0;
  localparam logic [1:0] OP_JUMP = 2'h1;
  localparam logic [1:0] OP_STEP = 2'h2;
  // ---------------------------------------------------------------
  // Host controller APB map
  // ---------------------------------------------------------------
  localparam logic [31:0] HREG_CMD  = 32'h0000_0000;
  localparam logic [31:0] HREG_STAT = 32'h0000_0004;
  localparam int HCMD_LOC_LSB = 8;
  localparam int HCMD_WR_BIT  = 16;
  localparam int HSTAT_BUSY   = 8;
  localparam int HSTAT_IRQ    = 9;
endpackage
`default_nettype wire

// [hdl/trh_bus_if.sv]
/*
  Parallel register bus between host microcontroller logic and the device.
  Assumes both ends run on the same clock; strobes are one-cycle pulses.
*/
`default_nettype none
interface trh_bus_if;
  logic [2:0] loc;
  logic       wrStb;
  logic       rdStb;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rdValid;
  logic       irq;
  modport host   (output loc, wrStb, rdStb, wdata, input rdata, rdValid, irq);
  modport device (input loc, wrStb, rdStb, wdata, output rdata, rdValid, irq);
endinterface
`default_nettype wire

// [hdl/trh_sequencer.sv]
/*
  Protocol microsequencer: clock dividers, program store, fetch, decode,
  timed no-op loop, jumps and the rebuild timer.
  Assumes the 50 MHz system clock and a clock enable from the device end.
*/
`default_nettype none
module trh_sequencer
  import trh_pkg::*;
#(
  parameter int REBUILD_LEN = trh_pkg::REBUILD_CYCLES
)(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  // Sequencer state
  output logic [trh_pkg::ROM_AW-1:0]    pc,
  output logic                          rebuildEvt
);
  typedef enum {FETCH_OP, FETCH_IMM, EXEC, WAIT} trh_seq_state_t;
  trh_seq_state_t state, next_state;
  logic [2:0]  divCnt, next_divCnt;
  logic        execPhase, next_execPhase;
  logic [7:0]  opReg, next_opReg, immReg, next_immReg, waitCnt, next_waitCnt;
  logic [ROM_AW-1:0] next_pc;
  logic [31:0] rbCnt, next_rbCnt;
  logic        next_rebuildEvt, pcTick, execTick;

  // Program store contents
  function automatic logic [7:0] romByte(input logic [ROM_AW-1:0] a);
    case (a)
      10'h000: romByte = {OP_NOP, 6'h00};
      10'h001: romByte = 8'h03;
      10'h002: romByte = {OP_STEP, 6'h00};
      10'h003: romByte = 8'h00;
      10'h004: romByte = {OP_JUMP, 6'h00};
      10'h005: romByte = 8'h00;
      default: romByte = 8'h00;
    endcase
  endfunction

  function automatic logic [ROM_AW-1:0] incPc(input logic [ROM_AW-1:0] a);
    incPc = (a == ROM_AW'(ROM_DEPTH - 1)) ? '0 : a + 1'b1;
  endfunction

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb
  begin
    pcTick = (divCnt == PC_DIV_LAST);
    execTick = pcTick & execPhase;
    next_divCnt = pcTick ? 3'h0 : divCnt + 3'h1;
    next_execPhase = pcTick ? ~execPhase : execPhase;
    next_state = state;
    next_pc = pc;
    next_opReg = opReg;
    next_immReg = immReg;
    next_waitCnt = waitCnt;
    next_rebuildEvt = 1'b0;
    case (state)
      FETCH_OP:  if (pcTick)
                 begin
                   next_opReg = romByte(pc);
                   next_pc = incPc(pc);
                   next_state = FETCH_IMM;
                 end
      FETCH_IMM: if (pcTick)
                 begin
                   next_immReg = romByte(pc);
                   next_pc = incPc(pc);
                   next_state = EXEC;
                 end
      EXEC:      if (execTick)
                 begin
                   next_state = FETCH_OP;
                   case (opReg[7:6])
                     OP_NOP:
                     begin
                       next_waitCnt = immReg;
                       next_state = WAIT;
                     end
                     OP_JUMP: next_pc = {opReg[1:0], immReg};
                     default: next_state = FETCH_OP;
                   endcase
                 end
      WAIT:      if (execTick)
                 begin
                   if (waitCnt == 8'h00)
                     next_state = FETCH_OP;
                   else
                     next_waitCnt = waitCnt - 8'h01;
                 end
      default:   next_state = FETCH_OP;
    endcase
    next_rbCnt = rbCnt + 32'h1;
    if (rbCnt == 32'(REBUILD_LEN - 1))
    begin
      next_rbCnt = 32'h0;
      next_pc = '0;
      next_state = FETCH_OP;
      next_rebuildEvt = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= FETCH_OP;
      divCnt <= 3'h0;
      execPhase <= 1'b0;
      pc <= '0;
      opReg <= 8'h00;
      immReg <= 8'h00;
      waitCnt <= 8'h00;
      rbCnt <= 32'h0;
      rebuildEvt <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      divCnt <= next_divCnt;
      execPhase <= next_execPhase;
      pc <= next_pc;
      opReg <= next_opReg;
      immReg <= next_immReg;
      waitCnt <= next_waitCnt;
      rbCnt <= next_rbCnt;
      rebuildEvt <= next_rebuildEvt;
    end
  end
endmodule // trh_sequencer
`default_nettype wire

// [hdl/trh_host.sv]
/*
  Host end: APB slave taking orders from software and running single
  register cycles on the device bus, reporting read data and interrupt.
  Assumes APB on the same clock as the device bus.
*/
`default_nettype none
module trh_host
  import trh_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Device register bus
  trh_bus_if.host          bus
);
  typedef enum {IDLE, WAIT_RD} trh_host_state_t;
  trh_host_state_t state, next_state;
  logic [31:0] next_prdata;
  logic [7:0]  lastRd, next_lastRd, next_wdata;
  logic [2:0]  next_loc;
  logic        next_pready, next_pslverr, next_wr, next_rd, access, busy;

  // --------------------------------------------------------------
  // Next values
  // --------------------------------------------------------------
  always_comb
  begin
    access = psel & penable & ~pready;
    busy = (state == WAIT_RD);
    next_state = state;
    next_pready = access;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    next_lastRd = lastRd;
    next_loc = bus.loc;
    next_wdata = bus.wdata;
    next_wr = 1'b0;
    next_rd = 1'b0;
    if (access)
    begin
      next_prdata = 32'h0000_0000;
      if (paddr == HREG_CMD)
      begin
        if (pwrite && !busy)
        begin
          // location and data byte chosen by software
          next_loc = pwdata[HCMD_LOC_LSB +: LOC_W];
          next_wdata = pwdata[DW-1:0];
          next_wr = pwdata[HCMD_WR_BIT];
          next_rd = ~pwdata[HCMD_WR_BIT];
          if (!pwdata[HCMD_WR_BIT])
            next_state = WAIT_RD;
        end
      end
      else if (paddr == HREG_STAT)
      begin
        next_prdata[DW-1:0] = lastRd;
        next_prdata[HSTAT_BUSY] = busy;
        next_prdata[HSTAT_IRQ] = bus.irq;
      end
      else
        next_pslverr = 1'b1;
    end
    case (state)
      IDLE:    next_state = next_state;
      WAIT_RD: if (bus.rdValid)
               begin
                 next_lastRd = bus.rdata;
                 next_state = IDLE;
               end
      default: next_state = IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= IDLE;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      lastRd <= 8'h00;
      bus.loc <= 3'h0;
      bus.wdata <= 8'h00;
      bus.wrStb <= 1'b0;
      bus.rdStb <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      lastRd <= next_lastRd;
      bus.loc <= next_loc;
      bus.wdata <= next_wdata;
      bus.wrStb <= next_wr;
      bus.rdStb <= next_rd;
    end
  end
endmodule // trh_host
`default_nettype wire

// [test/trh_bus_asserts.sv]
/*
  Checker of the register bus between the host and device ends.
  Assumes one clock; the bench drops ce only between bus cycles.
*/
`default_nettype none
module trh_bus_asserts
  import trh_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Bus signals
  input  wire logic [2:0] loc,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rdValid,
  input  wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lastMask;
  logic [7:0] next_lastMask;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Track the last mask byte sent to the device
  always_comb next_lastMask = (wrStb && loc == LOC_STATUS) ? wdata : lastMask;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) lastMask <= 8'h00;
    else lastMask <= next_lastMask;

  // Mask write that enables no capable flag, then a quiet spell
  sequence maskOff;
    wrStb && loc == LOC_STATUS && (wdata & IRQ_CAPABLE) == 8'h00;
  endsequence
  sequence noMaskWr;
    !(wrStb && loc == LOC_STATUS);
  endsequence

  a_read_answer: assert property (rdStb |=> rdValid)
    else $error("read strobe not answered");
  a_answer_cause: assert property (rdValid |-> $past(rdStb))
    else $error("answer without read");
  a_answer_once: assert property (rdValid |=> !rdValid)
    else $error("answer longer than one cycle");
  a_data_hold: assert property (!rdValid |-> $stable(rdata))
    else $error("read data moved without answer");
  a_strobe_single: assert property ((wrStb || rdStb) |=> !(wrStb || rdStb))
    else $error("strobe longer than one cycle");
  a_strobe_excl: assert property (!(wrStb && rdStb))
    else $error("read and write together");
  a_mask_gate: assert property (irq |->
      ((lastMask | $past(lastMask) | $past(lastMask, 2)) & IRQ_CAPABLE) != 8'h00)
    else $error("interrupt with no mask bit set");
  a_mask_off: assert property (maskOff ##1 noMaskWr [*3] |-> !irq)
    else $error("interrupt despite cleared mask");
endmodule // trh_bus_asserts
`default_nettype wire

// [test/test_token_ring_host_registers.sv]
/*
  Bench: APB drives the host end, which runs cycles on the device end.
  Assumes the package constants and a 50 MHz clock.
*/
`default_nettype none
module test_token_ring_host_registers
  import trh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] PG [4] = '{PG_PROBE, PG_OWN, PG_SETUP_A, PG_SETUP_B};
  localparam logic [7:0] MK [4] = '{8'hff, 8'hff, 8'hdf, 8'h9f};
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        rxInhibit = 0, txAvail = 0, excessNakEvt = 0, successorLoad = 0;
  logic        pready, pslverr, err, cmdStrobe, ce = 1;
  logic [7:0]  cmdCode, probeStation, ownStation, linkSetupA, linkSetupB;
  logic [5:0]  configHi;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [7:0]  successorIn = 0, v [5];
  logic [15:0] q [$];
  int          nFail = 0, checked = 0, nCmd = 0;

  trh_bus_if bus ();
  trh_host trh_host_i (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus.host));
  trh_device #(.REBUILD_LEN(400)) trh_device_i (.clk(clk), .rst_n(rst_n), .ce(ce),
    .bus(bus.device), .rxInhibit(rxInhibit), .txAvail(txAvail), .excessNakEvt(excessNakEvt),
    .successorLoad(successorLoad), .successorIn(successorIn), .cmdStrobe(cmdStrobe),
    .cmdCode(cmdCode), .probeStation(probeStation), .ownStation(ownStation),
    .linkSetupA(linkSetupA), .linkSetupB(linkSetupB), .configHi(configHi), .seqPc());
  trh_bus_asserts trh_bus_asserts_i (.clk(clk), .rst_n(rst_n), .loc(bus.loc),
    .wrStb(bus.wrStb), .rdStb(bus.rdStb), .wdata(bus.wdata), .rdata(bus.rdata),
    .rdValid(bus.rdValid), .irq(bus.irq));

  // Clock
  always #10 clk = ~clk;

  // Compare and count
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      nFail++;
      $display("[FAIL] %0t saw %h expected %h", $time, s, e);
    end
  endtask

  // Verdict and end of run
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Device cycle via the host; reads note {care mask, value}
  task automatic dev(input logic w, input logic [2:0] l, input logic [7:0] d,
                     input logic [15:0] e = 16'h0);
    if (!w) q.push_back(e);
    apb(1'b1, HREG_CMD, {15'h0, w, 5'h0, l, d});
    do apb(1'b0, HREG_STAT, 32'h0); while (rd[HSTAT_BUSY] !== 1'b0);
  endtask

  // Compare each read answer with the oldest note
  always @(posedge clk)
    if (bus.rdValid === 1'b1)
    begin
      check(bus.rdata & q[0][15:8], q[0][7:0]);
      void'(q.pop_front());
    end

  // Count command strobes
  always @(posedge clk) if (cmdStrobe === 1'b1) nCmd++;

  // Watchdog
  initial
  begin
    #200_000;
    nFail++;
    stopTest();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(64));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rxInhibit <= 1'b1;
    repeat (4) @(posedge clk);
    check(bus.irq, 8'h0);
    dev(1'b1, LOC_STATUS, 8'h80);
    check(bus.irq, 8'h1);
    check(rd[HSTAT_IRQ], 8'h1);
    dev(1'b1, LOC_STATUS, 8'h70);
    check(bus.irq, 8'h0);
    dev(1'b1, LOC_STATUS, 8'h80);
    check(bus.irq, 8'h1);
    rxInhibit <= 1'b0;
    txAvail <= 1'b1;
    dev(1'b1, LOC_STATUS, 8'h01);
    check(bus.irq, 8'h1);
    txAvail <= 1'b0;
    excessNakEvt <= 1'b1;
    @(posedge clk);
    excessNakEvt <= 1'b0;
    dev(1'b1, LOC_STATUS, 8'h08);
    dev(1'b1, LOC_DIAG, CMD_CLEAR_FLAGS);
    check(bus.irq, 8'h1);
    dev(1'b1, LOC_DIAG, CMD_POR_CLEAR);
    check(bus.irq, 8'h0);
    // Rebuild timeout stays pending until the clear command
    dev(1'b1, LOC_STATUS, 8'h04);
    repeat (410) @(posedge clk);
    check(bus.irq, 8'h1);
    dev(1'b0, LOC_DIAG, 8'h0, 16'h8080);
    dev(1'b1, LOC_DIAG, CMD_CLEAR_FLAGS);
    check(bus.irq, 8'h0);
    check(cmdCode, CMD_CLEAR_FLAGS);
    // Successor load, refused test write, clearing read
    v[4] = 8'($urandom);
    successorIn <= v[4];
    successorLoad <= 1'b1;
    @(posedge clk);
    successorLoad <= 1'b0;
    dev(1'b1, LOC_STATUS, 8'h02);
    check(bus.irq, 8'h1);
    dev(1'b1, LOC_PAGE, {5'h0, PG_SUCC});
    dev(1'b1, LOC_PAGED, 8'h00);
    dev(1'b0, LOC_PAGED, 8'h0, {8'hff, v[4]});
    check(bus.irq, 8'h0);
    // Paged registers, undefined bits written as zero
    foreach (PG[i])
    begin
      v[i] = 8'($urandom) & MK[i];
      dev(1'b1, LOC_PAGE, {5'h0, PG[i]});
      dev(1'b1, LOC_PAGED, v[i]);
    end
    foreach (PG[i])
    begin
      dev(1'b1, LOC_PAGE, {5'h0, PG[i]});
      dev(1'b0, LOC_PAGED, 8'h0, {MK[i], v[i]});
    end
    check(probeStation, v[0]);
    check(ownStation, v[1]);
    check(linkSetupA, v[2]);
    check(linkSetupB, v[3]);
    dev(1'b1, LOC_CONFIG, 8'hfc);
    dev(1'b0, LOC_CONFIG, 8'h0, 16'hfffc);
    check(configHi, 8'h3f);
    // Packet RAM across the pointer wrap, stepping pointer
    dev(1'b1, LOC_PTR_HI, 8'h47);
    dev(1'b1, LOC_PTR_LO, 8'hfe);
    for (int i = 0; i < 3; i++)
    begin
      v[i] = 8'($urandom);
      dev(1'b1, LOC_DATA, v[i]);
    end
    dev(1'b1, LOC_PTR_HI, 8'hc7);
    dev(1'b1, LOC_PTR_LO, 8'hfe);
    for (int i = 0; i < 3; i++) dev(1'b0, LOC_DATA, 8'h0, {8'hff, v[i]});
    // Frozen while ce is low, then a mid-run reset clears the mask
    dev(1'b1, LOC_STATUS, 8'h80);
    ce <= 1'b0;
    rxInhibit <= 1'b1;
    repeat (4) @(posedge clk);
    check(bus.irq, 8'h0);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    check(bus.irq, 8'h1);
    check(8'(nCmd), 8'h3);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(bus.irq, 8'h0);
    // Unmapped APB address
    apb(1'b0, 32'h0000_0010, 32'h0);
    check(err, 8'h1);
    check(8'(q.size()), 8'h0);
    repeat (4) @(posedge clk);
    stopTest();
  end
endmodule // test_token_ring_host_registers
`default_nettype wire
